// >>> hdl/mad_motion_detector.sv
/*
 * Activity / inactivity detector with referenced and absolute forms,
 * default, linked and loop interaction, awake flag and autosleep.
 * Assumes one sample strobe per output_sample_rate period on
 * i_sample_valid, axis data valid beside it, inputs synchronous to i_clk.
 */
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "mad_defines.svh"
module mad_motion_detector
   import mad_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [`MAD_ADDR_W-1:0] i_addr,
   input wire logic [`MAD_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`MAD_DATA_W-1:0] o_rdata,
   input wire logic i_sample_valid,
   input wire logic signed [`MAD_SAMPLE_W-1:0] i_accel_x,
   input wire logic signed [`MAD_SAMPLE_W-1:0] i_accel_y,
   input wire logic signed [`MAD_SAMPLE_W-1:0] i_accel_z,
   output logic o_int,
   output logic o_awake,
   output logic o_wakeup_mode
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic mad_mag_t mad_dist(input mad_sample_t a, input mad_sample_t r);
      logic signed [`MAD_SAMPLE_W:0] d;
      d = {a[`MAD_SAMPLE_W-1], a} - {r[`MAD_SAMPLE_W-1], r};
      mad_dist = d[`MAD_SAMPLE_W] ? mad_mag_t'(-d) : mad_mag_t'(d);
   endfunction

   function automatic mad_mag_t mad_thr(input logic [`MAD_THRESH_W-1:0] t);
      mad_thr = {2'b00, t};
   endfunction

   // ----------------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------------
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic [`MAD_THRESH_W-1:0] act_thresh;
   logic [`MAD_ACT_TIME_W-1:0] act_time;
   logic [`MAD_THRESH_W-1:0] inact_thresh;
   logic [`MAD_INACT_TIME_W-1:0] inact_time;
   logic [`MAD_CTRL_W-1:0] ctrl;
   logic [`MAD_MAP_W-1:0] int_map;
   logic act_flag;
   logic inact_flag;
   logic awake;
   logic [`MAD_ACT_TIME_W-1:0] act_cnt;
   logic [`MAD_INACT_TIME_W-1:0] inact_cnt;
   logic act_cap_pend;
   logic act_run_q;
   mad_watch_t watch;
   mad_link_t link;
   mad_sample_t sample [3];
   mad_sample_t act_ref [3];
   mad_sample_t inact_ref [3];
   logic run;
   logic wakeup_eff;
   logic act_on;
   logic inact_on;
   logic act_qual;
   logic inact_ok;
   logic act_hit;
   logic inact_hit;
   logic stat_rd;
   logic [`MAD_ACT_TIME_W-1:0] act_tmin;
   logic [`MAD_INACT_TIME_W-1:0] inact_tmin;

   assign sample[0] = i_accel_x;
   assign sample[1] = i_accel_y;
   assign sample[2] = i_accel_z;
   assign stat_rd = i_rd && (i_addr == `MAD_REG_STATUS);

   // ----------------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------------
   always_comb begin
      unique case (ctrl[`MAD_CTRL_LINK_HI:`MAD_CTRL_LINK_LO])
         2'b00: link = MAD_LINK_DEFAULT;
         2'b01: link = MAD_LINK_LINKED;
         default: link = MAD_LINK_LOOP;
      endcase
   end

   assign run = ctrl[`MAD_CTRL_MEASURE];
   // autosleep is ignored in default mode; sleep follows the awake flag
   assign wakeup_eff = run && (ctrl[`MAD_CTRL_WAKEUP] || (ctrl[`MAD_CTRL_AUTOSLEEP]
                       && link != MAD_LINK_DEFAULT && !awake));

   always_comb begin
      act_on = 1'b0;
      inact_on = 1'b0;
      unique case (link)
         MAD_LINK_DEFAULT: begin
            act_on = ctrl[`MAD_CTRL_ACT_EN] && !act_flag;
            inact_on = ctrl[`MAD_CTRL_INACT_EN] && !inact_flag;
         end
         MAD_LINK_LINKED: begin
            act_on = ctrl[`MAD_CTRL_ACT_EN] && watch == MAD_WATCH_ACT && !inact_flag;
            inact_on = ctrl[`MAD_CTRL_INACT_EN] && watch == MAD_WATCH_INACT && !act_flag;
         end
         MAD_LINK_LOOP: begin
            act_on = ctrl[`MAD_CTRL_ACT_EN] && watch == MAD_WATCH_ACT;
            inact_on = ctrl[`MAD_CTRL_INACT_EN] && watch == MAD_WATCH_INACT;
         end
      endcase
      act_on = act_on && run;
      inact_on = inact_on && run;
   end

   // ----------------------------------------------------------------------
   // per-axis qualification
   // ----------------------------------------------------------------------
   always_comb begin
      mad_sample_t r;
      r = '0;
      act_qual = 1'b0;
      inact_ok = 1'b1;
      for (int i = 0; i < 3; i++) begin
         r = ctrl[`MAD_CTRL_ACT_REF] ? act_ref[i] : mad_sample_t'(0);
         if (mad_dist(sample[i], r) > mad_thr(act_thresh)) begin
            act_qual = 1'b1;
         end
         r = ctrl[`MAD_CTRL_INACT_REF] ? inact_ref[i] : mad_sample_t'(0);
         if (mad_dist(sample[i], r) >= mad_thr(inact_thresh)) begin
            inact_ok = 1'b0;
         end
      end
   end

   // a zero time reads as a single sample, so no sample ever slips through unfiltered
   assign act_tmin = (act_time == '0) ? `MAD_ACT_TIME_W'(1) : act_time;
   assign inact_tmin = (inact_time == '0) ? `MAD_INACT_TIME_W'(1) : inact_time;

   assign act_hit = i_sample_valid && act_on && !act_cap_pend && act_qual
                    && (wakeup_eff || act_cnt >= act_tmin - 1'b1);
   assign inact_hit = i_sample_valid && inact_on && inact_ok
                      && inact_cnt >= inact_tmin - 1'b1;

   // ----------------------------------------------------------------------
   // duration counters
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_cnt <= '0;
      end else if (!act_on || act_hit) begin
         act_cnt <= '0;
      end else if (i_sample_valid) begin
         act_cnt <= (act_qual && !act_cap_pend) ? act_cnt + 1'b1 : '0;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         inact_cnt <= '0;
      end else if (!inact_on || inact_hit) begin
         inact_cnt <= '0;
      end else if (i_sample_valid) begin
         inact_cnt <= inact_ok ? inact_cnt + 1'b1 : '0;
      end
   end

   // ----------------------------------------------------------------------
   // references
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_run_q <= 1'b0;
         act_cap_pend <= 1'b0;
      end else begin
         act_run_q <= ctrl[`MAD_CTRL_ACT_EN] && run;
         if ((ctrl[`MAD_CTRL_ACT_EN] && run && !act_run_q)
             || (link != MAD_LINK_DEFAULT && inact_hit)
             || (link == MAD_LINK_DEFAULT && act_hit)) begin
            act_cap_pend <= 1'b1;
         end else if (i_sample_valid && act_on) begin
            act_cap_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 3; i++) begin
            act_ref[i] <= '0;
         end
      end else if (i_sample_valid && act_on && act_cap_pend) begin
         for (int i = 0; i < 3; i++) begin
            act_ref[i] <= sample[i];
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 3; i++) begin
            inact_ref[i] <= '0;
         end
      end else if (i_sample_valid && run && ctrl[`MAD_CTRL_INACT_REF] && !inact_ok) begin
         for (int i = 0; i < 3; i++) begin
            inact_ref[i] <= sample[i];
         end
      end
   end

   // ----------------------------------------------------------------------
   // detector alternation and motion state
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         watch <= MAD_WATCH_ACT;
      end else if (link == MAD_LINK_DEFAULT) begin
         watch <= MAD_WATCH_ACT;
      end else if (act_hit) begin
         watch <= MAD_WATCH_INACT;
      end else if (inact_hit) begin
         watch <= MAD_WATCH_ACT;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         awake <= `MAD_AWAKE_RST;
      end else if (act_hit) begin
         awake <= 1'b1;
      end else if (inact_hit) begin
         awake <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // event flags: a new event wins over the clearing read
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_flag <= 1'b0;
         inact_flag <= 1'b0;
      end else begin
         if (act_hit) begin
            act_flag <= 1'b1;
         end else if (stat_rd || (link == MAD_LINK_LOOP && inact_hit)) begin
            act_flag <= 1'b0;
         end
         if (inact_hit) begin
            inact_flag <= 1'b1;
         end else if (stat_rd || (link == MAD_LINK_LOOP && act_hit)) begin
            inact_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_thresh <= `MAD_THRESH_RST;
         act_time <= `MAD_ACT_TIME_RST;
         inact_thresh <= `MAD_THRESH_RST;
         inact_time <= `MAD_INACT_TIME_RST;
         ctrl <= `MAD_CTRL_RST;
         int_map <= `MAD_MAP_RST;
      end else if (i_wr) begin
         unique case (i_addr)
            `MAD_REG_ACT_THRESH: act_thresh <= i_wdata[`MAD_THRESH_W-1:0];
            `MAD_REG_ACT_TIME: act_time <= i_wdata[`MAD_ACT_TIME_W-1:0];
            `MAD_REG_INACT_THRESH: inact_thresh <= i_wdata[`MAD_THRESH_W-1:0];
            `MAD_REG_INACT_TIME: inact_time <= i_wdata[`MAD_INACT_TIME_W-1:0];
            `MAD_REG_CTRL: ctrl <= i_wdata[`MAD_CTRL_W-1:0];
            `MAD_REG_INT_MAP: int_map <= i_wdata[`MAD_MAP_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         unique case (i_addr)
            `MAD_REG_ACT_THRESH: o_rdata <= `MAD_DATA_W'(act_thresh);
            `MAD_REG_ACT_TIME: o_rdata <= `MAD_DATA_W'(act_time);
            `MAD_REG_INACT_THRESH: o_rdata <= `MAD_DATA_W'(inact_thresh);
            `MAD_REG_INACT_TIME: o_rdata <= inact_time;
            `MAD_REG_CTRL: o_rdata <= `MAD_DATA_W'(ctrl);
            `MAD_REG_STATUS: o_rdata <= `MAD_DATA_W'({wakeup_eff, awake, inact_flag, act_flag});
            `MAD_REG_INT_MAP: o_rdata <= `MAD_DATA_W'(int_map);
            default: o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_int <= 1'b0;
         o_awake <= `MAD_AWAKE_RST;
         o_wakeup_mode <= 1'b0;
      end else begin
         // routing awake onto the line gives a stand-alone motion switch
         o_int <= |(int_map & {awake, inact_flag, act_flag});
         o_awake <= awake;
         o_wakeup_mode <= wakeup_eff;
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   act_flag_set_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      act_hit |=> act_flag ##1 (o_int || !$past(int_map[0])))
      else $error("activity event did not set flag");
   awake_follow_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (inact_hit && !act_hit) |=> !awake ##1 !o_awake)
      else $error("inactivity did not clear awake");
   reset_disable_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      !ctrl[`MAD_CTRL_ACT_EN] |-> !act_hit && (ctrl[`MAD_CTRL_INACT_EN] || !inact_hit))
      else $error("detector fired while disabled");
   read_clear_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (stat_rd && !act_hit) |=> !act_flag && !$past(act_hit))
      else $error("status read did not clear activity flag");
   linked_wait_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (link == MAD_LINK_LINKED && inact_flag) |-> !act_hit)
      else $error("linked mode advanced before servicing");
   wakeup_single_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (i_sample_valid && wakeup_eff && act_on && !act_cap_pend && act_qual) |-> act_hit)
      else $error("wake-up mode did not use single-sample activity");
   inact_count_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      inact_hit |-> (inact_cnt == inact_tmin - 1'b1))
      else $error("inactivity declared early");
   loop_advance_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (link == MAD_LINK_LOOP && act_hit) |=> watch == MAD_WATCH_INACT && !inact_flag)
      else $error("loop mode did not advance");
   act_capture_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (i_sample_valid && act_on && act_cap_pend)
      |=> act_ref[0] == $past(i_accel_x) && act_ref[2] == $past(i_accel_z))
      else $error("activity reference not captured");
   inact_reload_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (i_sample_valid && run && ctrl[`MAD_CTRL_INACT_REF] && !inact_ok)
      |=> inact_ref[2] == $past(i_accel_z) && inact_cnt == '0)
      else $error("inactivity reference not reloaded");

endmodule

// >>> hdl/mad_defines.svh
/*
 * Register offsets, field positions, reset values and sample-count limits
 * of the motion activity detector.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef MAD_DEFINES_SVH
`define MAD_DEFINES_SVH

// ----------------------------------------------------------------------
// register bus geometry and offsets
// ----------------------------------------------------------------------
`define MAD_ADDR_W 4
`define MAD_DATA_W 16
`define MAD_REG_ACT_THRESH 4'h0
`define MAD_REG_ACT_TIME 4'h1
`define MAD_REG_INACT_THRESH 4'h2
`define MAD_REG_INACT_TIME 4'h3
`define MAD_REG_CTRL 4'h4
`define MAD_REG_STATUS 4'h5
`define MAD_REG_INT_MAP 4'h6

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MAD_CTRL_ACT_EN 0
`define MAD_CTRL_ACT_REF 1
`define MAD_CTRL_INACT_EN 2
`define MAD_CTRL_INACT_REF 3
`define MAD_CTRL_LINK_LO 4
`define MAD_CTRL_LINK_HI 5
`define MAD_CTRL_AUTOSLEEP 6
`define MAD_CTRL_MEASURE 7
`define MAD_CTRL_WAKEUP 8
`define MAD_CTRL_W 9
`define MAD_STAT_ACT 0
`define MAD_STAT_INACT 1
`define MAD_STAT_AWAKE 2
`define MAD_STAT_WAKEUP 3
`define MAD_MAP_W 3

// ----------------------------------------------------------------------
// widths, limits and reset values
// ----------------------------------------------------------------------
`define MAD_SAMPLE_W 12
`define MAD_THRESH_W 11
`define MAD_ACT_TIME_W 8
`define MAD_INACT_TIME_W 16
`define MAD_ACT_TIME_MAX_S 20
`define MAD_INACT_TIME_MAX 16'hFFFF
`define MAD_MIN_SAMPLE_PERIOD_US 2500
`define MAD_CTRL_RST 9'h000
`define MAD_THRESH_RST 11'h000
`define MAD_ACT_TIME_RST 8'h00
`define MAD_INACT_TIME_RST 16'h0000
`define MAD_MAP_RST 3'h0
`define MAD_AWAKE_RST 1'b1

`endif

// >>> hdl/mad_pkg.sv
/*
 * Types shared by the motion activity detector.
 * Assumes mad_defines.svh is on the include path.
 */
package mad_pkg;
   `include "mad_defines.svh"

   typedef enum logic [1:0] {MAD_LINK_DEFAULT, MAD_LINK_LINKED, MAD_LINK_LOOP} mad_link_t;
   typedef enum logic {MAD_WATCH_ACT, MAD_WATCH_INACT} mad_watch_t;
   typedef logic signed [`MAD_SAMPLE_W-1:0] mad_sample_t;
   typedef logic [`MAD_SAMPLE_W:0] mad_mag_t;
endpackage

// >>> dv/mad_host_model.sv
/*
 * Host processor model: drives the register port of the motion activity
 * detector and services its interrupt line by reading status.
 * Assumes the same clock as the detector and a bench that calls its tasks.
 */
`timescale 1ns/100ps
`include "mad_defines.svh"
module mad_host_model
   import mad_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_int,
   input wire logic [`MAD_DATA_W-1:0] i_rdata,
   output logic [`MAD_ADDR_W-1:0] o_addr,
   output logic [`MAD_DATA_W-1:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   initial begin
      o_addr = '0;
      o_wdata = '0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // ----------------------------------------------------------------
   // register cycles
   // ----------------------------------------------------------------
   // detectors stay off until the host writes the control word
   task automatic wr(input logic [`MAD_ADDR_W-1:0] a, input logic [`MAD_DATA_W-1:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask

   task automatic rd(input logic [`MAD_ADDR_W-1:0] a, output logic [`MAD_DATA_W-1:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      @(posedge i_clk);
      d = i_rdata;
   endtask

   // the status read is what rearms events in default and linked modes
   task automatic service(output logic [`MAD_DATA_W-1:0] d, output logic seen);
      seen = 1'b0;
      for (int i = 0; i < 50 && !seen; i++) begin
         @(posedge i_clk);
         seen = (i_int === 1'b1);
      end
      rd(`MAD_REG_STATUS, d);
   endtask
endmodule

// >>> dv/motion_activity_detector_bench.sv
/*
 * Self-checking bench of the motion activity detector: directed corner
 * cases plus seeded random inactivity samples.
 * Assumes mad_pkg and the host model are compiled first.
 */
`timescale 1ns/100ps
`include "mad_defines.svh"
module motion_activity_detector_bench
   import mad_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sv = 1'b0;
   mad_sample_t ax = '0;
   mad_sample_t ay = '0;
   mad_sample_t az = '0;
   logic [`MAD_ADDR_W-1:0] addr;
   logic [`MAD_DATA_W-1:0] wdata;
   logic [`MAD_DATA_W-1:0] rdata;
   logic [`MAD_DATA_W-1:0] d;
   logic wr;
   logic rd;
   logic irq;
   logic awake;
   logic wkm;
   logic seen;
   logic [15:0] rnd = 16'h003A;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int x;
   int y;
   int z;

   always #5 clk = ~clk;

   mad_motion_detector dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sample_valid(sv), .i_accel_x(ax),
      .i_accel_y(ay), .i_accel_z(az), .o_int(irq), .o_awake(awake), .o_wakeup_mode(wkm));
   mad_host_model host_u (.i_clk(clk), .i_int(irq), .i_rdata(rdata), .o_addr(addr),
      .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic int rv();
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      return int'(rnd[6:0]) - 64;
   endfunction

   // strict: a sample equal to the threshold is not still
   function automatic logic still(input int a, input int b, input int c, input int t);
      return (a < t && a > -t) && (b < t && b > -t) && (c < t && c > -t);
   endfunction

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask

   task automatic smp(input int a, input int b, input int c);
      @(posedge clk);
      sv <= 1'b1;
      ax <= mad_sample_t'(a);
      ay <= mad_sample_t'(b);
      az <= mad_sample_t'(c);
      @(posedge clk);
      sv <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic st(input logic [15:0] e);
      host_u.rd(`MAD_REG_STATUS, d);
      chk("status", e, d);
   endtask

   task automatic pins(input logic i, input logic a, input logic w);
      repeat (2) @(posedge clk);
      chk("pins", {13'h0000, i, a, w}, {13'h0000, irq, awake, wkm});
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // hang guard, far above the several hundred cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      pins(1'b0, 1'b1, 1'b0);
      host_u.rd(`MAD_REG_CTRL, d);
      chk("ctrl", 16'h0000, d);
      host_u.rd(4'hF, d);
      chk("unmapped", 16'h0000, d);
      host_u.wr(`MAD_REG_ACT_THRESH, 16'hF864);
      host_u.rd(`MAD_REG_ACT_THRESH, d);
      chk("act_thresh", 16'h0064, d);
      host_u.wr(`MAD_REG_ACT_TIME, 16'h0003);
      host_u.wr(`MAD_REG_INACT_THRESH, 16'h0032);
      host_u.wr(`MAD_REG_INACT_TIME, 16'h0001);
      host_u.wr(`MAD_REG_CTRL, 16'h0080);
      smp(900, 0, 0);
      smp(0, 0, 0);
      st(16'h0004);
      // absolute activity, three-sample timer
      host_u.wr(`MAD_REG_CTRL, 16'h0081);
      smp(0, 0, 0);
      smp(100, 0, 0);
      smp(0, -101, 0);
      smp(0, 0, 101);
      smp(0, 0, 0);
      smp(0, 0, -300);
      smp(-300, 0, 0);
      st(16'h0004);
      smp(0, 300, 0);
      st(16'h0005);
      st(16'h0004);
      // referenced activity, single-sample timer
      host_u.wr(`MAD_REG_CTRL, 16'h0000);
      host_u.wr(`MAD_REG_ACT_TIME, 16'h0001);
      host_u.wr(`MAD_REG_CTRL, 16'h0083);
      smp(500, -200, 300);
      smp(600, -200, 300);
      st(16'h0004);
      smp(500, -301, 300);
      st(16'h0005);
      smp(900, 900, 900);
      smp(900, 900, 900);
      st(16'h0004);
      smp(1001, 900, 900);
      st(16'h0005);
      // absolute inactivity, corner cases then random samples
      host_u.wr(`MAD_REG_CTRL, 16'h0084);
      smp(50, 0, 0);
      st(16'h0004);
      smp(49, -49, 49);
      st(16'h0002);
      for (int i = 0; i < 40; i++) begin
         x = rv();
         y = rv();
         z = rv();
         smp(x, y, z);
         st(still(x, y, z, 50) ? 16'h0002 : 16'h0000);
      end
      host_u.wr(`MAD_REG_INACT_TIME, 16'h0004);
      smp(0, 0, -60);
      for (int i = 0; i < 3; i++) smp(10, -10, 10);
      st(16'h0000);
      smp(10, -10, 10);
      st(16'h0002);
      // referenced inactivity with reference reload
      host_u.wr(`MAD_REG_INACT_TIME, 16'h0002);
      host_u.wr(`MAD_REG_CTRL, 16'h008C);
      smp(400, 400, 400);
      smp(430, 380, 410);
      st(16'h0000);
      smp(420, 355, 445);
      st(16'h0002);
      // linked mode, inactivity mapped to the interrupt
      host_u.wr(`MAD_REG_CTRL, 16'h0000);
      host_u.wr(`MAD_REG_INACT_TIME, 16'h0001);
      host_u.wr(`MAD_REG_INT_MAP, 16'h0002);
      host_u.wr(`MAD_REG_CTRL, 16'h0095);
      smp(200, 0, 0);
      smp(300, 0, 0);
      smp(0, 0, 0);
      st(16'h0005);
      smp(0, 0, 0);
      smp(300, 0, 0);
      host_u.service(d, seen);
      chk("irq seen", 16'h0001, {15'h0000, seen});
      chk("status", 16'h0002, d);
      pins(1'b0, 1'b0, 1'b0);
      smp(300, 0, 0);
      st(16'h0000);
      smp(300, 0, 0);
      smp(0, 0, 0);
      st(16'h0005);
      // loop mode with autosleep, no servicing
      host_u.wr(`MAD_REG_CTRL, 16'h0000);
      host_u.wr(`MAD_REG_ACT_TIME, 16'h0003);
      host_u.wr(`MAD_REG_CTRL, 16'h00E5);
      smp(200, 0, 0);
      for (int i = 0; i < 3; i++) smp(300, 0, 0);
      smp(0, 0, 0);
      pins(1'b1, 1'b0, 1'b1);
      smp(300, 0, 0);
      smp(300, 0, 0);
      pins(1'b0, 1'b1, 1'b0);
      st(16'h0005);
      // forced wake-up mode, activity mapped to the interrupt
      host_u.wr(`MAD_REG_INT_MAP, 16'h0001);
      host_u.wr(`MAD_REG_CTRL, 16'h0181);
      smp(300, 0, 0);
      pins(1'b1, 1'b1, 1'b1);
      st(16'h000D);
      end_of_test();
   end
endmodule
